// >>> include/board_decode_params.svh
`ifndef BOARD_DECODE_PARAMS_SVH
`define BOARD_DECODE_PARAMS_SVH

// primary decoder codes on a13..a12 while a15 is low; a15 high is rom
`define MAIN_SUB1_CODE   2'h0
`define MAIN_SUB2_CODE   2'h1

// first sub-decoder codes on a10..a8
`define SUB1_RAM         3'h0
`define SUB1_KEY_SCAN    3'h1
`define SUB1_ADAPTER     3'h2

// second sub-decoder codes on a2..a0
`define SUB2_DATA_LATCH  3'h0
`define SUB2_CTRL_PATH   3'h1
`define SUB2_DEV_FB      3'h2
`define SUB2_DISP_LATCH  3'h3
`define SUB2_STAT_LATCH  3'h4

// control-board decoder: latched a3 picks bank, a7..a6 picks line
`define CB_BANK_LOW      1'b0
`define CB_HIGH_LINES    2'h2
`define CB_DISP_WRITE    2'h2

// key drive steps
`define KEY_STEP_FIRST   3'h1
`define KEY_STEP_LAST    3'h6

// timing
`define CLK_PERIOD_NS    50
`define POR_HOLD_NS      2500000
`define POR_HOLD_CYC     ((`POR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIGIT_CYC        1000

// axi4-lite register map
`define REG_STATUS       4'h0
`define REG_CONTROL      4'h4
`define REG_DISP_INSTR   4'h8
`define CTRL_BLANK_BIT   0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// >>> include/board_pkg.sv
package board_pkg;

    typedef logic [7:0] byte_t;

    // one select per decoded target
    typedef struct packed {
        logic rom;
        logic ram;
        logic key_scan;
        logic adapter;
        logic data_latch;
        logic ctrl_path;
        logic dev_fb;
        logic disp_latch;
        logic stat_latch;
    } board_sel_s;

    // captured control-board address: a14 and a9..a3
    typedef struct packed {
        logic       mode;
        logic [6:0] addr;
    } cb_latch_s;

    typedef enum logic {POR_HOLD, POR_RUN} por_state_e;

endpackage : board_pkg

// >>> verilog/board_decode.sv
// Overview of operation
// - a15,a13,a12 pick rom or one sub-decoder
// - sub-decoder one: a10..a8 pick ram, keys, adapter
// - sub-decoder two: a2..a0 pick five latches
// - control path latches a3..a9, a14; drives a3..a9
// - latched a14 is display instruction/data selector
// - a6,a7 make six board strobes, display write
// - processor steps a3..a5 one..six; six drives
// - a2..a0 mux eight sense lines to key state
// - display holds eight bytes, segments plus point
// - low write: selector high instruction, low data
// - power-down blocks the ram select
// - power-on reset held about 2.5 ms
// - power-down asserts reset before supply loss
// - display latch drives parameter leds, status latch drives bus status leds
`timescale 1ns/100ps
`include "board_decode_params.svh"

module board_decode
    import board_pkg::*;
#(
    parameter int unsigned POR_CYCLES   = `POR_HOLD_CYC,
    parameter int unsigned DIGIT_CYCLES = `DIGIT_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_valid,
    input  wire logic        cpu_rw,
    input  wire byte_t       cpu_wdata,
    input  wire logic [7:0]  key_sense_lines,
    input  wire logic        power_down_det,
    output board_sel_s       selects_q,
    output logic [6:0]       ctrl_bus_q,
    output logic [5:0]       control_board_write_strobes_n_q,
    output logic [5:0]       key_drive_lines_q,
    output logic             key_state_q,
    output byte_t            param_leds_q,
    output byte_t            bus_status_leds_q,
    output logic [7:0]       digit_strobes_q,
    output byte_t            segments_q,
    output logic             cpu_reset_n_q,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    board_sel_s  sel_d;
    cb_latch_s   cb_q, cb_d;
    byte_t       cb_data_q, cb_data_d;
    logic        cb_pend_q, cb_pend_d;
    logic [6:0]  ctrl_bus_d;
    logic [5:0]  strobes_d;
    logic        disp_wr_n_q, disp_wr_n_d;
    logic [5:0]  drive_d;
    logic        key_state_d, sense_pick;
    byte_t       param_leds_d, bus_leds_d;
    byte_t       disp_mem [8];
    byte_t       instr_q, instr_d;
    logic [2:0]  disp_ptr_q, disp_ptr_d;
    logic        mem_we;
    logic [2:0]  digit_q, digit_d;
    logic [15:0] dig_cnt_q, dig_cnt_d;
    logic [7:0]  strobes_dig_d;
    byte_t       segments_d;
    por_state_e  por_q, por_d;
    logic [31:0] por_cnt_q, por_cnt_d;
    logic        reset_n_d;
    logic        blank_q, blank_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] rdata_d;

    assign sense_pick = key_sense_lines[cpu_addr[2:0]];

    // two-level address decode, latches, keys and strobes
    always_comb
    begin
        sel_d        = '0;
        cb_d         = cb_q;
        cb_data_d    = cb_data_q;
        cb_pend_d    = 1'b0;
        drive_d      = key_drive_lines_q;
        key_state_d  = key_state_q;
        param_leds_d = param_leds_q;
        bus_leds_d   = bus_status_leds_q;
        strobes_d    = '1;
        disp_wr_n_d  = 1'b1;
        if (cpu_valid)
        begin
            if (cpu_addr[15])
                sel_d.rom = 1'b1;
            else if (cpu_addr[13:12] == `MAIN_SUB1_CODE)
            begin
                case (cpu_addr[10:8])
                    `SUB1_RAM:      sel_d.ram = !power_down_det;
                    `SUB1_KEY_SCAN: sel_d.key_scan = 1'b1;
                    `SUB1_ADAPTER:  sel_d.adapter = 1'b1;
                    default:        sel_d = '0;
                endcase
            end
            else if (cpu_addr[13:12] == `MAIN_SUB2_CODE)
            begin
                case (cpu_addr[2:0])
                    `SUB2_DATA_LATCH: sel_d.data_latch = 1'b1;
                    `SUB2_CTRL_PATH:  sel_d.ctrl_path = 1'b1;
                    `SUB2_DEV_FB:     sel_d.dev_fb = 1'b1;
                    `SUB2_DISP_LATCH: sel_d.disp_latch = 1'b1;
                    `SUB2_STAT_LATCH: sel_d.stat_latch = 1'b1;
                    default:          sel_d = '0;
                endcase
            end
        end
        // capture a14 and a9..a3 for the control board
        if (sel_d.ctrl_path)
        begin
            cb_d      = '{mode: cpu_addr[14], addr: cpu_addr[9:3]};
            cb_data_d = cpu_wdata;
            cb_pend_d = !cpu_rw;
        end
        // control-board decoder on latched a7..a6, bank a3
        if (cb_pend_q)
        begin
            if (cb_q.addr[0] == `CB_BANK_LOW)
                strobes_d[cb_q.addr[4:3]] = 1'b0;
            else if (cb_q.addr[4:3] < `CB_HIGH_LINES)
                strobes_d[3'(cb_q.addr[4:3]) + 3'h4] = 1'b0;
            else if (cb_q.addr[4:3] == `CB_DISP_WRITE)
                disp_wr_n_d = 1'b0;
        end
        // key drive one-of-six and sense multiplexer
        if (sel_d.key_scan)
        begin
            for (int i = 0; i < 6; i++)
                drive_d[i] = (cpu_addr[5:3] == 3'(i + 1));
            key_state_d = sense_pick;
        end
        // front-panel led latches
        if (sel_d.disp_latch && !cpu_rw)
            param_leds_d = cpu_wdata;
        if (sel_d.stat_latch && !cpu_rw)
            bus_leds_d = cpu_wdata;
    end

    assign ctrl_bus_d = cb_q.addr;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            selects_q                       <= '0;
            cb_q                            <= '0;
            cb_data_q                       <= '0;
            cb_pend_q                       <= 1'b0;
            ctrl_bus_q                      <= '0;
            control_board_write_strobes_n_q <= '1;
            disp_wr_n_q                     <= 1'b1;
            key_drive_lines_q               <= '0;
            key_state_q                     <= 1'b0;
            param_leds_q                    <= '0;
            bus_status_leds_q               <= '0;
        end
        else
        begin
            selects_q                       <= sel_d;
            cb_q                            <= cb_d;
            cb_data_q                       <= cb_data_d;
            cb_pend_q                       <= cb_pend_d;
            ctrl_bus_q                      <= ctrl_bus_d;
            control_board_write_strobes_n_q <= strobes_d;
            disp_wr_n_q                     <= disp_wr_n_d;
            key_drive_lines_q               <= drive_d;
            key_state_q                     <= key_state_d;
            param_leds_q                    <= param_leds_d;
            bus_status_leds_q               <= bus_leds_d;
        end
    end

    // display driver load and digit multiplex
    always_comb
    begin
        instr_d    = instr_q;
        disp_ptr_d = disp_ptr_q;
        mem_we     = 1'b0;
        if (!disp_wr_n_q)
        begin
            if (cb_q.mode)
            begin
                instr_d    = cb_data_q;
                disp_ptr_d = '0;
            end
            else
            begin
                mem_we     = 1'b1;
                disp_ptr_d = disp_ptr_q + 3'h1;
            end
        end
        dig_cnt_d = dig_cnt_q + 16'h0001;
        digit_d   = digit_q;
        if (dig_cnt_q == 16'(DIGIT_CYCLES - 1))
        begin
            dig_cnt_d = '0;
            digit_d   = digit_q + 3'h1;
        end
        strobes_dig_d = 8'h01 << digit_q;
        segments_d    = blank_q ? 8'h00 : disp_mem[digit_q];
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we)
            disp_mem[disp_ptr_q] <= cb_data_q;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            instr_q         <= '0;
            disp_ptr_q      <= '0;
            dig_cnt_q       <= '0;
            digit_q         <= '0;
            digit_strobes_q <= '0;
            segments_q      <= '0;
        end
        else
        begin
            instr_q         <= instr_d;
            disp_ptr_q      <= disp_ptr_d;
            dig_cnt_q       <= dig_cnt_d;
            digit_q         <= digit_d;
            digit_strobes_q <= strobes_dig_d;
            segments_q      <= segments_d;
        end
    end

    // power-on hold and power-down reset
    always_comb
    begin
        por_d     = por_q;
        por_cnt_d = por_cnt_q;
        unique case (por_q)
            POR_HOLD:
            begin
                por_cnt_d = por_cnt_q + 32'h1;
                if (por_cnt_q == 32'(POR_CYCLES - 1))
                    por_d = POR_RUN;
            end
            POR_RUN: por_cnt_d = por_cnt_q;
        endcase
        if (power_down_det)
        begin
            por_d     = POR_HOLD;
            por_cnt_d = '0;
        end
        reset_n_d = (por_d == POR_RUN);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            por_q         <= POR_HOLD;
            por_cnt_q     <= '0;
            cpu_reset_n_q <= 1'b0;
        end
        else
        begin
            por_q         <= por_d;
            por_cnt_q     <= por_cnt_d;
            cpu_reset_n_q <= reset_n_d;
        end
    end

    // axi4-lite slave: status, control, display instruction
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = s_axi_bvalid && !s_axi_bready;
        bresp_d   = s_axi_bresp;
        rvalid_d  = s_axi_rvalid && !s_axi_rready;
        rresp_d   = s_axi_rresp;
        rdata_d   = s_axi_rdata;
        blank_d   = blank_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (aw_have_q && w_have_q && !s_axi_bvalid)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `RESP_OKAY;
            if (awaddr_q == `REG_CONTROL)
            begin
                if (wstrb_q[0])
                    blank_d = wdata_q[`CTRL_BLANK_BIT];
            end
            else if (awaddr_q != `REG_STATUS && awaddr_q != `REG_DISP_INSTR)
                bresp_d = `RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = `RESP_OKAY;
            unique case (s_axi_araddr)
                `REG_STATUS:     rdata_d = {20'h0, disp_ptr_q,
                                    key_drive_lines_q, key_state_q,
                                    power_down_det, cpu_reset_n_q};
                `REG_CONTROL:    rdata_d = {31'h0, blank_q};
                `REG_DISP_INSTR: rdata_d = {24'h0, instr_q};
                default:
                begin
                    rdata_d = '0;
                    rresp_d = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            blank_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= '0;
            s_axi_rdata   <= '0;
        end
        else
        begin
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            awaddr_q      <= awaddr_d;
            wdata_q       <= wdata_d;
            wstrb_q       <= wstrb_d;
            blank_q       <= blank_d;
            s_axi_awready <= !aw_have_d;
            s_axi_wready  <= !w_have_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            s_axi_arready <= !rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
        end
    end

    // checks on decode, key scan, display and reset
    default clocking cb_chk @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_sel_onehot: assert property ($onehot0(selects_q))
        else $error("more than one select active");
    a_main_rom: assert property (cpu_valid && cpu_addr[15]
        |=> selects_q.rom && !selects_q.ram)
        else $error("rom select missing");
    a_sub1_ram: assert property (cpu_valid && !cpu_addr[15]
        && cpu_addr[13:12] == `MAIN_SUB1_CODE
        && cpu_addr[10:8] == `SUB1_RAM && !power_down_det
        |=> selects_q.ram)
        else $error("ram select missing");
    a_sub2_disp: assert property (cpu_valid && !cpu_addr[15]
        && cpu_addr[13:12] == `MAIN_SUB2_CODE
        && cpu_addr[2:0] == `SUB2_DISP_LATCH
        |=> selects_q.disp_latch)
        else $error("display latch select missing");
    a_cb_capture: assert property (sel_d.ctrl_path
        |=> ##1 ctrl_bus_q == $past(cpu_addr[9:3], 2))
        else $error("control bus not latched address");
    a_cb_strobe: assert property (cb_pend_q && !cb_q.addr[0]
        |=> $countones(~control_board_write_strobes_n_q) == 1)
        else $error("control strobe not single");
    a_instr_load: assert property (!disp_wr_n_q && cb_q.mode
        |=> instr_q == $past(cb_data_q) && disp_ptr_q == 3'h0)
        else $error("instruction not loaded");
    a_data_step: assert property (!disp_wr_n_q && !cb_q.mode
        |=> disp_ptr_q == $past(disp_ptr_q) + 3'h1)
        else $error("display pointer did not step");
    a_key_drive: assert property (sel_d.key_scan
        && cpu_addr[5:3] == 3'h3
        |=> key_drive_lines_q == 6'h04)
        else $error("wrong key drive line");
    a_key_sense: assert property (sel_d.key_scan
        |=> key_state_q == $past(sense_pick))
        else $error("key state wrong");
    a_ram_block: assert property (power_down_det
        |=> !selects_q.ram)
        else $error("ram selected during power-down");
    a_pd_reset: assert property (power_down_det
        |=> !cpu_reset_n_q)
        else $error("reset missing on power-down");
    a_por_hold: assert property ($rose(cpu_reset_n_q)
        |-> por_cnt_q == 32'(POR_CYCLES))
        else $error("reset released early");
    a_led_latch: assert property (sel_d.disp_latch && !cpu_rw
        |=> param_leds_q == $past(cpu_wdata))
        else $error("parameter leds not loaded");

    c_key_scan: cover property (sel_d.key_scan ##1 key_state_q);
    c_disp_data: cover property (!disp_wr_n_q && !cb_q.mode);
    c_ram_sel: cover property (selects_q.ram);
    c_por_done: cover property ($rose(cpu_reset_n_q));

endmodule : board_decode

// >>> tb/cpu_model.sv
`timescale 1ns/100ps
module cpu_model
    import board_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [5:0]  key_drive_lines_q,
    output logic [15:0]      cpu_addr,
    output logic             cpu_valid,
    output logic             cpu_rw,
    output byte_t            cpu_wdata,
    output logic [7:0]       key_sense_lines
);
    logic       key_on;
    logic [2:0] key_d;
    logic [2:0] key_s;

    // quiet bus and no key pressed at start
    initial
    begin
        cpu_addr  = 16'h0000;
        cpu_valid = 1'b0;
        cpu_rw    = 1'b1;
        cpu_wdata = 8'h00;
        key_on    = 1'b0;
        key_d     = 3'h0;
        key_s     = 3'h0;
    end

    // key matrix: a pressed key joins one drive line to one sense line
    assign key_sense_lines = (key_on && key_drive_lines_q[key_d])
                           ? (8'h01 << key_s) : 8'h00;

    // one bus cycle; write data turns stale once the cycle ends
    task automatic access(input logic [15:0] a, input logic r,
                          input byte_t d);
        @(posedge core_clk);
        cpu_addr  <= a;
        cpu_rw    <= r;
        cpu_wdata <= d;
        cpu_valid <= 1'b1;
        @(posedge core_clk);
        cpu_valid <= 1'b0;
        cpu_wdata <= ~d;
    endtask : access
endmodule : cpu_model

// >>> tb/tb.sv
`timescale 1ns/100ps
`include "board_decode_params.svh"
module tb
    import board_pkg::*;
;
    localparam int unsigned POR = 20;
    localparam logic [15:0] DA [14] = '{16'h8000, 16'hc000, 16'h0000,
        16'h0100, 16'h0207, 16'h0300, 16'h1000, 16'h1001, 16'h1002,
        16'h1003, 16'h1004, 16'h1005, 16'h2000, 16'h3000};
    localparam logic [8:0] DS [14] = '{9'h100, 9'h100, 9'h080, 9'h040,
        9'h020, 9'h000, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001, 9'h000,
        9'h000, 9'h000};
    logic        core_clk, sys_rst, pd, cpu_valid, cpu_rw, kst, rstn;
    logic [15:0] cpu_addr;
    byte_t       cpu_wdata, pled, sled, seg;
    logic [7:0]  key_sense_lines, dig;
    board_sel_s  sel;
    logic [6:0]  cbus;
    logic [5:0]  wsn, drv;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          fails, tests_run;

    board_decode #(.POR_CYCLES(POR), .DIGIT_CYCLES(4)) DUT (
        .core_clk, .sys_rst, .cpu_addr, .cpu_valid, .cpu_rw, .cpu_wdata,
        .key_sense_lines, .power_down_det(pd), .selects_q(sel),
        .ctrl_bus_q(cbus), .control_board_write_strobes_n_q(wsn),
        .key_drive_lines_q(drv), .key_state_q(kst), .param_leds_q(pled),
        .bus_status_leds_q(sled), .digit_strobes_q(dig), .segments_q(seg),
        .cpu_reset_n_q(rstn), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    cpu_model cpu (.core_clk, .key_drive_lines_q(drv), .cpu_addr,
        .cpu_valid, .cpu_rw, .cpu_wdata, .key_sense_lines);

    // 20 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected=%h seen=%h", n, e, g);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic tmo(input string n);
        fails++;
        $display("[ERR] %s expected=answer seen=timeout", n);
        final_report();
    endtask : tmo

    // register write: address and data offered together, bready held
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] rs);
        int n;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        if (n == 50)
            tmo("axi_b");
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    // register read, rready held until rvalid
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
        int n;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        if (n == 50)
            tmo("axi_r");
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    function automatic byte_t dbyte(input int k);
        return byte_t'(8'h1d * (k + 1));
    endfunction : dbyte

    task automatic t_decode;
        for (int i = 0; i < 14; i++)
        begin
            cpu.access(DA[i], 1'b1, 8'h00);
            #1 chk("sel", DS[i], sel);
            @(posedge core_clk);
            #1 chk("sel_idle", 0, sel);
        end
        $display("decode test done");
    endtask : t_decode

    task automatic t_ctrl;
        logic [15:0] a;
        logic [5:0]  e;
        for (int i = 0; i < 6; i++)
        begin
            a = 16'h1201 | ((i > 3) ? 16'h0008 : 16'h0000) | 16'((i % 4) << 6);
            e = ~(6'h01 << i);
            cpu.access(a, 1'b0, 8'h00);
            @(posedge core_clk);
            #1 chk("strobes", e, wsn);
            chk("ctrl_bus", a[9:3], cbus);
            @(posedge core_clk);
        end
        cpu.access(16'h1201, 1'b1, 8'h00);
        @(posedge core_clk);
        #1 chk("strobes_read", 6'h3f, wsn);
        cpu.access(16'h12c9, 1'b0, 8'h00);
        @(posedge core_clk);
        #1 chk("no_strobe", 6'h3f, wsn);
        $display("control strobe test done");
    endtask : t_ctrl

    task automatic t_leds;
        cpu.access(16'h1003, 1'b0, 8'ha5);
        cpu.access(16'h1004, 1'b0, 8'h3c);
        @(posedge core_clk);
        #1 chk("param_leds", 8'ha5, pled);
        chk("status_leds", 8'h3c, sled);
        $display("led latch test done");
    endtask : t_leds

    task automatic t_disp;
        logic [7:0]  seen;
        logic [31:0] d;
        logic [1:0]  rs;
        seen = 8'h00;
        cpu.access(16'h5089, 1'b0, 8'h5a);
        @(posedge core_clk);
        // eight successive data writes, a read slipped in midway
        for (int k = 0; k < 8; k++)
        begin
            cpu.access(16'h1089, 1'b0, dbyte(k));
            @(posedge core_clk);
            if (k == 3)
                cpu.access(16'h1089, 1'b1, 8'hff);
        end
        repeat (3) @(posedge core_clk);
        repeat (80)
        begin
            @(posedge core_clk);
            #1;
            for (int j = 0; j < 8; j++)
                if (dig === (8'h01 << j))
                begin
                    seen[j] = 1'b1;
                    chk("segments", dbyte(j), seg);
                end
        end
        chk("digits_seen", 8'hff, seen);
        axi_rd(`REG_DISP_INSTR, d, rs);
        chk("disp_instr", 32'h5a, d);
        $display("display test done");
    endtask : t_disp

    task automatic t_keys;
        logic [5:0] e;
        @(posedge core_clk);
        cpu.key_on <= 1'b1;
        cpu.key_d  <= 3'h2;
        cpu.key_s  <= 3'h5;
        // step drive lines one to six, then an idle code
        for (int st = 1; st < 8; st++)
        begin
            e = (st < 7) ? 6'(1 << (st - 1)) : 6'h00;
            cpu.access(16'h0100 | 16'(st << 3), 1'b1, 8'h00);
            for (int s = 0; s < 8; s++)
            begin
                cpu.access(16'h0100 | 16'(st << 3 | s), 1'b1, 8'h00);
                #1 chk("drive", e, drv);
                chk("key_state", (st == 3 && s == 5), kst);
            end
        end
        $display("key scan test done");
    endtask : t_keys

    task automatic t_axi;
        logic [31:0] d;
        logic [1:0]  rs;
        logic        bad;
        bad = 1'b0;
        axi_rd(`REG_STATUS, d, rs);
        chk("status_resp", `RESP_OKAY, rs);
        chk("status_low", 2'b01, d[1:0]);
        axi_rd(4'hc, d, rs);
        chk("bad_rresp", `RESP_SLVERR, rs);
        chk("bad_rdata", 0, d);
        axi_wr(4'hc, 32'h1, 4'hf, rs);
        chk("bad_bresp", `RESP_SLVERR, rs);
        axi_wr(`REG_CONTROL, 32'h1, 4'hf, rs);
        repeat (4) @(posedge core_clk);
        repeat (40)
        begin
            @(posedge core_clk);
            #1 bad = bad | (dig !== 8'h00 && seg !== 8'h00);
        end
        chk("blanked", 0, bad);
        axi_wr(`REG_CONTROL, 32'h0, 4'h0, rs);
        axi_rd(`REG_CONTROL, d, rs);
        chk("ctrl_keep", 1, d[0]);
        $display("register test done");
    endtask : t_axi

    task automatic t_pdown;
        logic [31:0] d;
        logic [1:0]  rs;
        @(posedge core_clk);
        pd <= 1'b1;
        cpu.access(16'h0000, 1'b1, 8'h00);
        #1 chk("ram_sel_pd", 0, sel);
        chk("reset_pd", 0, rstn);
        cpu.access(16'h0100, 1'b1, 8'h00);
        #1 chk("key_sel_pd", 9'h040, sel);
        axi_rd(`REG_STATUS, d, rs);
        chk("status_pd", 2'b10, d[1:0]);
        @(posedge core_clk);
        pd <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1 chk("reset_rehold", 0, rstn);
        repeat (POR) @(posedge core_clk);
        #1 chk("reset_back", 1, rstn);
        $display("power-down test done");
    endtask : t_pdown

    // reset, then the scenarios in turn
    initial
    begin
        fails = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        pd = 1'b0;
        s_axi_awaddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 4'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        #1 chk("por_hold", 0, rstn);
        repeat (POR) @(posedge core_clk);
        #1 chk("por_done", 1, rstn);
        t_decode();
        t_ctrl();
        t_leds();
        t_disp();
        t_keys();
        t_axi();
        t_pdown();
        final_report();
    end
endmodule : tb
